//--- hw/cim_pkg.sv
// constants and types shared by the current input scaling and fault monitor
package cim_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ        = 200;
  localparam int SCAN_PERIOD_US = 10000;
  localparam int SCAN_CYCLES    = SCAN_PERIOD_US * CLK_MHZ;

  // ==========================================================================
  // channel and detector counts, event log depth
  localparam int NUM_CH      = 2;
  localparam int DET_PER_CH  = 3;
  localparam int NUM_DET     = NUM_CH * DET_PER_CH;
  localparam int LOG_DEPTH   = 16;

  // ==========================================================================
  // scales: currents in microamps, percentages in thousandths of a percent
  localparam logic [15:0] FULL_SCALE_UA   = 16'h55F0;
  localparam logic [16:0] PCT_FULL        = 17'h186A0;
  localparam logic [15:0] DEF_LO_UA       = 16'h0FA0;
  localparam logic [15:0] DEF_HI_UA       = 16'h4E20;
  localparam logic [15:0] DEF_SETPOINT_UA = 16'h0DAC;
  localparam logic [15:0] DEF_BW_UA       = 16'h01F4;
  localparam logic [15:0] DEF_DEBOUNCE    = 16'h0064;
  localparam logic [7:0]  DEF_TEXT        = 8'h00;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFF_CH_RANGE  = 8'h00;
  localparam logic [7:0] OFF_CH_INV    = 8'h04;
  localparam logic [7:0] OFF_CH_PCT    = 8'h08;
  localparam logic [7:0] OFF_CH_CUR    = 8'h0C;
  localparam logic [7:0] OFF_CH_STRIDE = 8'h20;
  localparam logic [7:0] OFF_DET_BASE  = 8'h40;
  localparam logic [7:0] OFF_DET_END   = 8'h70;
  localparam logic [7:0] OFF_STATUS    = 8'h80;
  localparam logic [7:0] OFF_MASK      = 8'h84;
  localparam logic [7:0] OFF_TIME      = 8'h88;
  localparam logic [7:0] OFF_LOG_LEVEL = 8'h8C;
  localparam logic [7:0] OFF_LOG_TIME  = 8'h90;
  localparam logic [7:0] OFF_LOG_INFO  = 8'h94;
  localparam logic [7:0] OFF_LOG_POP   = 8'h98;

  // ==========================================================================
  // detector config word 1 field positions, status layout
  localparam int CFG_TEXT_LSB = 16;
  localparam int CFG_CAT_LSB  = 24;
  localparam int CFG_EN_BIT   = 31;
  localparam int STS_OVF_BIT  = 6;
  localparam int STS_W        = 7;

  // event categories attached to log entries
  typedef enum logic [1:0] {
    CAT_INFO    = 2'b00,
    CAT_WARNING = 2'b01,
    CAT_ERROR   = 2'b10,
    CAT_OTHER   = 2'b11
  } cat_t;

endpackage : cim_pkg

//--- hw/current_scaler.sv
// linear scaling of one channel's current to a percentage, with inversion
`timescale 1ns/1ps
module current_scaler (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // sample and settings
  input  wire logic [15:0] cur,
  input  wire logic [15:0] lo,
  input  wire logic [15:0] hi,
  input  wire logic        inv,
  // result
  output logic      [16:0] pct
);
  logic [15:0] span;
  logic [15:0] above;
  logic [33:0] quo;
  logic [16:0] lin;
  logic [16:0] next_pct;

  // ==========================================================================
  // interpolation; a reversed or empty range reads as the lower end
  always_comb
  begin
    span  = hi - lo;
    above = cur - lo;
    quo   = (span == 16'h0000) ? 34'h000000000
          : (34'(above) * 34'(cim_pkg::PCT_FULL)) / 34'(span);
    if (hi <= lo || cur <= lo)
      lin = 17'h00000;
    else if (cur >= hi)
      lin = cim_pkg::PCT_FULL;
    else
      lin = quo[16:0];
    next_pct = inv ? cim_pkg::PCT_FULL - lin : lin;
  end

  // result register, thousandths of a percent
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pct <= 17'h00000;
    else
      pct <= next_pct;
  end

  a_pct_in_range: assert property (@(posedge pclk) disable iff (!presetn)
    pct <= cim_pkg::PCT_FULL) else $error("percentage above full scale");
  // the register took the inversion setting of the previous cycle
  a_pct_upper_end: assert property (@(posedge pclk) disable iff (!presetn)
    (hi > lo && cur >= hi) |=> pct == ($past(inv) ? 17'h00000 : cim_pkg::PCT_FULL))
    else $error("upper range current mapped wrongly");

endmodule : current_scaler

//--- hw/fault_detector.sv
// one fault band detector with debounce, advanced on each scan tick
`timescale 1ns/1ps
module fault_detector (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // scan
  input  wire logic        tick,
  input  wire logic [15:0] cur,
  // settings
  input  wire logic [15:0] setpoint,
  input  wire logic [15:0] bandwidth,
  input  wire logic [15:0] debounce,
  input  wire logic        enable,
  // event
  output logic             fire
);
  logic [15:0] band_lo;
  logic [16:0] band_hi;
  logic        in_band;
  logic [15:0] dwell;
  logic        fired;

  // band reaches bandwidth either side of the setpoint, floored at zero
  always_comb
  begin
    band_lo = (setpoint > bandwidth) ? setpoint - bandwidth : 16'h0000;
    band_hi = {1'b0, setpoint} + {1'b0, bandwidth};
    in_band = cur >= band_lo && {1'b0, cur} <= band_hi;
  end

  // dwell counts earlier in-band scans; one event per excursion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dwell <= 16'h0000;
      fired <= 1'b0;
      fire  <= 1'b0;
    end
    else
    begin
      fire <= 1'b0;
      if (!enable)
      begin
        dwell <= 16'h0000;
        fired <= 1'b0;
      end
      else if (tick)
      begin
        if (!in_band)
        begin
          dwell <= 16'h0000;
          fired <= 1'b0;
        end
        else if (!fired && dwell >= debounce)
        begin
          fire  <= 1'b1;
          fired <= 1'b1;
        end
        else if (!fired)
          dwell <= dwell + 16'h0001;
      end
    end
  end

  a_fire_needs_band: assert property (@(posedge pclk) disable iff (!presetn)
    fire |-> $past(enable) && $past(tick) && $past(in_band) && $past(dwell) >= $past(debounce))
    else $error("fault event without full dwell in band");
  a_fire_once: assert property (@(posedge pclk) disable iff (!presetn)
    fire |=> !fire) else $error("fault event longer than one cycle");

endmodule : fault_detector

//--- hw/current_input_monitor.sv
// top: two current input channels, scaling, fault detectors, event log, APB
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module current_input_monitor #(
  parameter int SCAN_CYCLES = cim_pkg::SCAN_CYCLES,
  parameter int LOG_DEPTH   = cim_pkg::LOG_DEPTH
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // converter codes in microamps, asynchronous to pclk
  input  wire logic [15:0] current_input_first,
  input  wire logic [15:0] current_input_second,
  // results
  output logic      [16:0] pct_first,
  output logic      [16:0] pct_second,
  output logic             irq
);
  localparam int LW = $clog2(LOG_DEPTH);
  // ==========================================================================
  // state
  logic [15:0] sync1 [cim_pkg::NUM_CH];
  logic [15:0] sync2 [cim_pkg::NUM_CH];
  logic [15:0] cur_q [cim_pkg::NUM_CH];
  logic [16:0] pct   [cim_pkg::NUM_CH];
  logic [15:0] lo    [cim_pkg::NUM_CH];
  logic [15:0] hi    [cim_pkg::NUM_CH];
  logic        inv   [cim_pkg::NUM_CH];
  logic [15:0] sp    [cim_pkg::NUM_DET];
  logic [15:0] bw    [cim_pkg::NUM_DET];
  logic [15:0] deb   [cim_pkg::NUM_DET];
  logic [7:0]  txt   [cim_pkg::NUM_DET];
  logic [1:0]  cat   [cim_pkg::NUM_DET];
  logic        en    [cim_pkg::NUM_DET];
  logic [cim_pkg::NUM_DET-1:0] fire;
  logic [cim_pkg::NUM_DET-1:0] pending;
  logic [31:0] scan_cnt;
  logic        tick;
  logic [31:0] time_now;
  logic [44:0] log_mem [LOG_DEPTH];
  logic [LW:0] wptr;
  logic [LW:0] rptr;
  logic [LW:0] level;
  logic [cim_pkg::STS_W-1:0] status;
  logic [cim_pkg::STS_W-1:0] mask;
  logic        have;
  logic [2:0]  pick;
  logic        log_full;
  logic        log_empty;
  logic        do_pop;
  logic        ovf;
  // ==========================================================================
  // bus decode
  logic        access;
  logic        wr;
  logic        ch_reg;
  logic        ch_sel;
  logic        det_reg;
  logic [7:0]  det_off;
  logic [2:0]  det_idx;
  logic        addr_ok;
  logic [31:0] next_rdata;
  assign access  = psel && penable && !pready;
  assign wr      = psel && penable && pready && pwrite && !pslverr;
  assign ch_reg  = paddr[7:6] == 2'b00;
  assign ch_sel  = paddr[5];
  assign det_off = paddr - cim_pkg::OFF_DET_BASE;
  assign det_reg = paddr >= cim_pkg::OFF_DET_BASE && paddr < cim_pkg::OFF_DET_END;
  assign det_idx = det_off[5:3];
  // read mux and address check; misaligned or unknown offsets give an error
  always_comb
  begin
    next_rdata = 32'h00000000;
    addr_ok    = paddr[1:0] == 2'b00;
    if (ch_reg && paddr[4] == 1'b0)
      case ({paddr[3:2], 2'b00})
        cim_pkg::OFF_CH_RANGE[3:0]: next_rdata = {hi[ch_sel], lo[ch_sel]};
        cim_pkg::OFF_CH_INV[3:0]:   next_rdata = {31'h00000000, inv[ch_sel]};
        cim_pkg::OFF_CH_PCT[3:0]:   next_rdata = {15'h0000, pct[ch_sel]};
        default:                    next_rdata = {16'h0000, cur_q[ch_sel]};
      endcase
    else if (det_reg)
      next_rdata = det_off[2] ? {en[det_idx], 5'h00, cat[det_idx], txt[det_idx],
                                 deb[det_idx]}
                              : {bw[det_idx], sp[det_idx]};
    else
      case (paddr)
        cim_pkg::OFF_STATUS:    next_rdata = {25'h0000000, status};
        cim_pkg::OFF_MASK:      next_rdata = {25'h0000000, mask};
        cim_pkg::OFF_TIME:      next_rdata = time_now;
        cim_pkg::OFF_LOG_LEVEL: next_rdata = {{(31-LW){1'b0}}, level};
        cim_pkg::OFF_LOG_TIME:  next_rdata = log_mem[rptr[LW-1:0]][44:13];
        cim_pkg::OFF_LOG_INFO:  next_rdata = {19'h00000, log_mem[rptr[LW-1:0]][12:0]};
        cim_pkg::OFF_LOG_POP:   next_rdata = 32'h00000000;
        default:                addr_ok    = 1'b0;
      endcase
  end
  // one wait state: data and error are registered on the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= access;
      pslverr <= access && !addr_ok;
      if (access)
        prdata <= pwrite ? 32'h00000000 : next_rdata;
    end
  end

  // ==========================================================================
  // input synchronisers; only the second stage feeds the sampler
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int c = 0; c < cim_pkg::NUM_CH; c++)
      begin
        sync1[c] <= 16'h0000;
        sync2[c] <= 16'h0000;
      end
    else
    begin
      sync1[0] <= current_input_first;
      sync1[1] <= current_input_second;
      for (int c = 0; c < cim_pkg::NUM_CH; c++)
        sync2[c] <= sync1[c];
    end
  end
  // scan timer: one tick per scan period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scan_cnt <= 32'h00000000;
      tick     <= 1'b0;
    end
    else
    begin
      tick     <= scan_cnt == 32'(SCAN_CYCLES - 1);
      scan_cnt <= (scan_cnt == 32'(SCAN_CYCLES - 1)) ? 32'h00000000
                : scan_cnt + 32'h00000001;
    end
  end
  // sample held for a whole scan so scaler and detectors see one value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int c = 0; c < cim_pkg::NUM_CH; c++)
        cur_q[c] <= 16'h0000;
    else if (scan_cnt == 32'h00000000)
      for (int c = 0; c < cim_pkg::NUM_CH; c++)
        cur_q[c] <= (sync2[c] > cim_pkg::FULL_SCALE_UA) ? cim_pkg::FULL_SCALE_UA
                  : sync2[c];
  end

  // ==========================================================================
  // settings; the retained copy is restored by software after power-up,
  // so reset values are only the factory defaults
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < cim_pkg::NUM_CH; c++)
      begin
        lo[c]  <= cim_pkg::DEF_LO_UA;
        hi[c]  <= cim_pkg::DEF_HI_UA;
        inv[c] <= 1'b0;
      end
      for (int d = 0; d < cim_pkg::NUM_DET; d++)
      begin
        sp[d]  <= cim_pkg::DEF_SETPOINT_UA;
        bw[d]  <= cim_pkg::DEF_BW_UA;
        deb[d] <= cim_pkg::DEF_DEBOUNCE;
        txt[d] <= cim_pkg::DEF_TEXT;
        cat[d] <= cim_pkg::CAT_INFO;
        en[d]  <= 1'b0;
      end
    end
    else if (wr && ch_reg && paddr[4:2] == cim_pkg::OFF_CH_RANGE[4:2])
    begin
      lo[ch_sel] <= pwdata[15:0];
      hi[ch_sel] <= pwdata[31:16];
    end
    else if (wr && ch_reg && paddr[4:2] == cim_pkg::OFF_CH_INV[4:2])
      inv[ch_sel] <= pwdata[0];
    else if (wr && det_reg && !det_off[2])
    begin
      sp[det_idx] <= pwdata[15:0];
      bw[det_idx] <= pwdata[31:16];
    end
    else if (wr && det_reg)
    begin
      deb[det_idx] <= pwdata[15:0];
      txt[det_idx] <= pwdata[cim_pkg::CFG_TEXT_LSB +: 8];
      cat[det_idx] <= pwdata[cim_pkg::CFG_CAT_LSB +: 2];
      en[det_idx]  <= pwdata[cim_pkg::CFG_EN_BIT];
    end
  end

  // ==========================================================================
  // per-channel scalers and detectors, identical for both channels
  for (genvar c = 0; c < cim_pkg::NUM_CH; c++)
  begin : g_ch
    current_scaler u_scaler (
      .pclk    (pclk),
      .presetn (presetn),
      .cur     (cur_q[c]),
      .lo      (lo[c]),
      .hi      (hi[c]),
      .inv     (inv[c]),
      .pct     (pct[c])
    );
  end

  for (genvar d = 0; d < cim_pkg::NUM_DET; d++)
  begin : g_det
    fault_detector u_det (
      .pclk      (pclk),
      .presetn   (presetn),
      .tick      (tick),
      .cur       (cur_q[d / cim_pkg::DET_PER_CH]),
      .setpoint  (sp[d]),
      .bandwidth (bw[d]),
      .debounce  (deb[d]),
      .enable    (en[d]),
      .fire      (fire[d])
    );
  end

  assign pct_first  = pct[0];
  assign pct_second = pct[1];
  // ==========================================================================
  // time stamp in scan periods; a software write sets it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      time_now <= 32'h00000000;
    else if (wr && paddr == cim_pkg::OFF_TIME)
      time_now <= pwdata;
    else if (tick)
      time_now <= time_now + 32'h00000001;
  end
  // lowest pending detector is logged first; several may fire in one scan
  always_comb
  begin
    pick = 3'h0;
    for (int i = cim_pkg::NUM_DET - 1; i >= 0; i--)
      if (pending[i])
        pick = 3'(i);
  end

  assign have      = |pending;
  assign level     = wptr - rptr;
  assign log_full  = level == (LW + 1)'(LOG_DEPTH);
  assign log_empty = level == '0;
  assign do_pop    = wr && paddr == cim_pkg::OFF_LOG_POP && pwdata[0] && !log_empty;
  assign ovf       = have && log_full;
  // pending events: a new fire wins over the clear of the same bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending <= '0;
    else
      for (int i = 0; i < cim_pkg::NUM_DET; i++)
        pending[i] <= fire[i] || (pending[i] && !(have && pick == 3'(i)));
  end

  // log ring: entry is time, category, detector number and text code;
  // a full log drops the entry and flags overflow rather than stalling scans
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      if (have && !log_full)
      begin
        log_mem[wptr[LW-1:0]] <= {time_now, cat[pick], pick, txt[pick]};
        wptr <= wptr + 1'b1;
      end
      if (do_pop)
        rptr <= rptr + 1'b1;
    end
  end

  // ==========================================================================
  // sticky status, write one to clear; a set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= '0;
      mask   <= '0;
      irq    <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < cim_pkg::STS_W; i++)
        status[i] <= (i == cim_pkg::STS_OVF_BIT ? ovf : fire[i % cim_pkg::NUM_DET])
                  || (status[i] && !(wr && paddr == cim_pkg::OFF_STATUS && pwdata[i]));
      if (wr && paddr == cim_pkg::OFF_MASK)
        mask <= pwdata[cim_pkg::STS_W-1:0];
      irq <= |(status & mask);
    end
  end

  // ==========================================================================
  // checks
  sequence apb_wait;
    psel && penable && !pready ##1 pready;
  endsequence

  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |-> apb_wait) else $error("APB answer not one wait");
  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    |(status & mask) |=> irq) else $error("interrupt missing for unmasked status");
  a_log_bound: assert property (@(posedge pclk) disable iff (!presetn)
    level <= (LW + 1)'(LOG_DEPTH)) else $error("log level beyond depth");
  a_log_push: assert property (@(posedge pclk) disable iff (!presetn)
    (have && !log_full && !do_pop) |=> level == $past(level) + 1'b1)
    else $error("pending event not logged");
  a_fire_enabled: assert property (@(posedge pclk) disable iff (!presetn)
    fire[0] |-> $past(en[0])) else $error("disabled detector fired");
  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> !tick) else $error("scan ticks too close");
  a_sample_clip: assert property (@(posedge pclk) disable iff (!presetn)
    cur_q[0] <= cim_pkg::FULL_SCALE_UA && cur_q[1] <= cim_pkg::FULL_SCALE_UA)
    else $error("sample beyond full scale");
  a_event_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    fire[0] |=> status[0]) else $error("event did not set status");

endmodule : current_input_monitor

//--- test/field_instrument.sv
// field instrument model: current loop source feeding both input channels
`timescale 1ns/1ps
module field_instrument (
  // loop settings chosen by the bench
  input  wire logic [15:0] level_first,
  input  wire logic [15:0] level_second,
  input  wire logic        loop_open,
  // loop currents in microamps
  output logic      [15:0] current_input_first,
  output logic      [15:0] current_input_second
);
  // a broken loop carries no current at all, like a cut wire
  assign current_input_first  = loop_open ? 16'h0000 : level_first;
  assign current_input_second = loop_open ? 16'h0000 : level_second;
endmodule : field_instrument

//--- test/tb.sv
// self-checking bench for the current input monitor
`timescale 1ns/1ps
module tb;
  // short scan so a debounce run takes under a hundred cycles
  localparam int SCAN = 20;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        err;
  logic        loop_open = 1'h0;
  logic [15:0] cur_first;
  logic [15:0] cur_second;
  logic [15:0] lvl [2] = '{16'h0000, 16'h0000};
  logic [16:0] pct [2];
  logic [16:0] ep [2];
  int          err_count = 0;
  int          num_checks = 0;
  int          seed = 67;
  int          lo [2];
  int          hi [2];
  int          cin [2];
  bit          inv [2];

  always #2.5 pclk = ~pclk;

  field_instrument u_field_instrument (.level_first(lvl[0]), .level_second(lvl[1]),
    .loop_open(loop_open), .current_input_first(cur_first),
    .current_input_second(cur_second));

  current_input_monitor #(.SCAN_CYCLES(SCAN), .LOG_DEPTH(16)) u_current_input_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .current_input_first(cur_first), .current_input_second(cur_second),
    .pct_first(pct[0]), .pct_second(pct[1]), .irq(irq));

  // ==========================================================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // one apb transfer; pready is sampled at the rising edge, as the slave sees it,
  // and the request is released only after that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1)
    begin
      err_count++;
      results();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
    end
  endtask : apb

  // clipping, linear map and inversion of one reading
  function automatic logic [16:0] exp_pct(input int c, input int l, input int h, input bit iv);
    longint v;
    if (c > cim_pkg::FULL_SCALE_UA)
      c = cim_pkg::FULL_SCALE_UA;
    if (h <= l || c <= l)
      v = 0;
    else if (c >= h)
      v = cim_pkg::PCT_FULL;
    else
      v = (longint'(c - l) * cim_pkg::PCT_FULL) / (h - l);
    if (iv)
      v = cim_pkg::PCT_FULL - v;
    return 17'(v);
  endfunction : exp_pct

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, 8'h20, 32'h0);
    check(rd, 32'h4E200FA0);
    apb(1'h0, 8'h48, 32'h0);
    check(rd, 32'h01F40DAC);
    apb(1'h0, 8'hFC, 32'h0);
    check({rd[30:0], err}, 32'h1);
    $display("test reset and map done");
    // random settings per channel, corners first: at lo, at hi, over range, open loop
    for (int i = 0; i < 6; i++)
    begin
      for (int c = 0; c < 2; c++)
      begin
        lo[c] = $random(seed) & 32'h3FFF;
        hi[c] = lo[c] + 100 + ($random(seed) & 32'h1FFF);
        inv[c] = 1'($random(seed));
        cin[c] = (i == 0) ? lo[c] : (i == 1) ? hi[c] : (i == 2) ? 23000 : $random(seed) & 32'h7FFF;
        if (i == 3)
          cin[c] = 0;
        ep[c] = exp_pct(cin[c], lo[c], hi[c], inv[c]);
        apb(1'h1, 8'(c * 32), {hi[c][15:0], lo[c][15:0]});
        apb(1'h1, 8'(c * 32 + 4), {31'h0, inv[c]});
        lvl[c] <= (i == 3) ? 16'h2EE0 : 16'(cin[c]);
      end
      loop_open <= (i == 3);
      repeat (3 * SCAN) @(posedge pclk);
      @(negedge pclk);
      check({15'h0, pct[0]}, {15'h0, ep[0]});
      check({15'h0, pct[1]}, {15'h0, ep[1]});
      @(posedge pclk);
      for (int c = 0; c < 2; c++)
      begin
        apb(1'h0, 8'(c * 32 + 8), 32'h0);
        check(rd, {15'h0, ep[c]});
        apb(1'h0, 8'(c * 32 + 12), 32'h0);
        check(rd, (cin[c] > 22000) ? 32'h55F0 : 32'(cin[c]));
      end
    end
    $display("test scaling done");
    // fault band 20000..22000 on detector 0, same band disabled on detector 1
    loop_open <= 1'h0;
    lvl[0] <= 16'h1388;
    repeat (3 * SCAN) @(posedge pclk);
    apb(1'h1, 8'h40, 32'h03E85208);
    apb(1'h1, 8'h44, 32'h825A0002);
    apb(1'h1, 8'h48, 32'h03E85208);
    apb(1'h1, 8'h84, 32'h3);
    apb(1'h1, 8'h88, 32'h00010000);
    // two short stays at 22000, on the band's inclusive upper edge, must not fire
    for (int k = 0; k < 2; k++)
    begin
      lvl[0] <= 16'h55F0;
      repeat (2 * SCAN) @(posedge pclk);
      lvl[0] <= 16'h1388;
      repeat (3 * SCAN) @(posedge pclk);
    end
    apb(1'h0, 8'h80, 32'h0);
    check(rd, 32'h0);
    lvl[0] <= 16'h4E20;
    repeat (6 * SCAN) @(posedge pclk);
    apb(1'h0, 8'h80, 32'h0);
    check(rd, 32'h1);
    check({31'h0, irq}, 32'h1);
    apb(1'h0, 8'h8C, 32'h0);
    check(rd, 32'h1);
    apb(1'h0, 8'h94, 32'h0);
    check(rd, 32'h105A);
    apb(1'h0, 8'h90, 32'h0);
    check({31'h0, rd >= 32'h00010000 && rd < 32'h00010100}, 32'h1);
    // masking, clearing and popping
    apb(1'h1, 8'h84, 32'h0);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    @(posedge pclk);
    apb(1'h1, 8'h80, 32'h1);
    apb(1'h1, 8'h98, 32'h1);
    apb(1'h0, 8'h80, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 8'h8C, 32'h0);
    check(rd, 32'h0);
    $display("test fault events done");
    results();
  end
endmodule : tb
